// *** ufb_underflow_status_bank.sv ***
/*
 * Latched clear-on-read underflow flags for channel input FIFOs 49..112,
 * four 16-bit words behind a classic Wishbone slave, plus a per-word
 * sticky event status with mask driving one level interrupt.
 * Assumes one clock, event strobes synchronous to clk_sys, and a
 * single-cycle Wishbone master that waits for ack.
 */
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ufb_map.svh"

module ufb_underflow_status_bank (
    input  wire logic                  clk_sys,        // System clock, 40 MHz
    input  wire logic                  arst_n,         // Asynchronous reset, active low
    input  wire logic                  wb_cyc_i,       // Wishbone cycle
    input  wire logic                  wb_stb_i,       // Wishbone strobe
    input  wire logic                  wb_we_i,        // Wishbone write enable
    input  wire logic [15:0]           wb_adr_i,       // Wishbone byte address
    input  wire logic [3:0]            wb_sel_i,       // Wishbone byte selects
    input  wire ufb_pkg::ufb_bus_word_t wb_dat_i,      // Wishbone write data
    output logic      [31:0]           wb_dat_o,       // Wishbone read data
    output logic                       wb_ack_o,       // Wishbone acknowledge
    input  wire logic [63:0]           uflow_evt_i,    // Underflow strobes, bit n = chan 49+n
    output logic                       irq_o           // Level interrupt, active high
);
    import ufb_pkg::*;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    localparam int NW = `UFB_NUM_WORDS;
    localparam int FW = `UFB_FLAG_W;

    localparam ufb_idx_t FLAG_IDX [NW] = '{
        `UFB_IDX_FLAGS_CH49_64,
        `UFB_IDX_FLAGS_CH65_80,
        `UFB_IDX_FLAGS_CH81_96,
        `UFB_IDX_FLAGS_CH97_112
    };

    // One-hot hit vector: flag words, then irq status, then irq mask
    function automatic logic [NW+1:0] ufb_decode(input ufb_idx_t idx);
        logic [NW+1:0] hit;
        hit = '0;
        for (int i = 0; i < NW; i++) begin
            hit[i] = (idx == FLAG_IDX[i]);
        end
        hit[NW]   = (idx == `UFB_IDX_IRQ_STATUS);
        hit[NW+1] = (idx == `UFB_IDX_IRQ_MASK);
        return hit;
    endfunction : ufb_decode

    ufb_idx_t       req_idx;
    logic [NW+1:0]  req_hit;
    logic           bus_req;
    logic           rd_req;
    logic           wr_req;

    // Byte lanes [1:0] of the address are ignored: one register per word
    assign req_idx = wb_adr_i[`UFB_IDX_W+1:2];
    assign req_hit = ufb_decode(req_idx);
    // wb_ack_o gates out the second cycle so one request is served once
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_req  = bus_req & ~wb_we_i;
    assign wr_req  = bus_req & wb_we_i;

    // ------------------------------------------------------------------------
    // Underflow flag words
    // ------------------------------------------------------------------------
    ufb_flag_word_t flag_reg  [NW];
    ufb_flag_word_t flag_next [NW];
    ufb_group_t     grp_evt;

    for (genvar g = 0; g < NW; g++) begin : g_word
        ufb_flag_word_t evt_w;
        ufb_flag_word_t keep_w;

        assign evt_w  = uflow_evt_i[g*FW +: FW];
        // Clear the whole word on a read of it, whatever the byte selects
        assign keep_w = (rd_req && req_hit[g]) ? '0 : flag_reg[g];
        // Events are ORed in after the clear so a colliding event survives
        assign flag_next[g] = keep_w | evt_w;
        assign grp_evt[g]   = |evt_w;

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                flag_reg[g] <= `UFB_FLAGS_RESET;
            end else begin
                flag_reg[g] <= flag_next[g];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    ufb_group_t irq_stat_reg;
    ufb_group_t irq_stat_next;
    ufb_group_t irq_mask_reg;
    ufb_group_t irq_w1c;

    assign irq_w1c = (wr_req && req_hit[NW] && wb_sel_i[0]) ? wb_dat_i[NW-1:0] : '0;
    // Set wins over a write-one-to-clear in the same cycle
    assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | grp_evt;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_reg <= `UFB_IRQ_RESET;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_reg <= `UFB_IRQ_RESET;
        end else if (wr_req && req_hit[NW+1] && wb_sel_i[0]) begin
            irq_mask_reg <= wb_dat_i[NW-1:0];
        end
    end

    // Registered output, so irq lags the status bit by one cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------------------
    // Read mux and bus answer
    // ------------------------------------------------------------------------
    ufb_bus_word_t rd_word;

    always_comb begin
        rd_word = `UFB_DATA_RESET;
        for (int i = 0; i < NW; i++) begin
            if (req_hit[i]) begin
                rd_word = {16'h0000, flag_reg[i]};
            end
        end
        if (req_hit[NW]) begin
            rd_word = {28'h000_0000, irq_stat_reg};
        end
        if (req_hit[NW+1]) begin
            rd_word = {28'h000_0000, irq_mask_reg};
        end
    end

    // Unmapped addresses are acknowledged with zero data, writes dropped
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Data is sampled at the same edge that clears the word
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= `UFB_DATA_RESET;
        end else if (rd_req) begin
            wb_dat_o <= rd_word;
        end
    end

endmodule : ufb_underflow_status_bank
`default_nettype wire

// *** ufb_map.svh ***
/*
 * Register map constants for the underflow status bank: register indices,
 * reset values and field layout.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef UFB_MAP_SVH
`define UFB_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define UFB_IDX_W               14
`define UFB_IDX_FLAGS_CH49_64   14'h058E
`define UFB_IDX_FLAGS_CH65_80   14'h058F
`define UFB_IDX_FLAGS_CH81_96   14'h0590
`define UFB_IDX_FLAGS_CH97_112  14'h0591
`define UFB_IDX_IRQ_STATUS      14'h05A0
`define UFB_IDX_IRQ_MASK        14'h05A1

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define UFB_FLAG_W              16
`define UFB_NUM_WORDS           4
`define UFB_FIRST_CHAN          49
`define UFB_FLAGS_RESET         16'h0000
`define UFB_IRQ_RESET           4'h0
`define UFB_DATA_RESET          32'h0000_0000

`endif

// *** ufb_pkg.sv ***
/*
 * Types shared by the underflow status bank and its surroundings.
 * Assumes ufb_map.svh is on the include path.
 */
`include "ufb_map.svh"

package ufb_pkg;

    typedef logic [`UFB_IDX_W-1:0]     ufb_idx_t;
    typedef logic [`UFB_FLAG_W-1:0]    ufb_flag_word_t;
    typedef logic [`UFB_NUM_WORDS-1:0] ufb_group_t;
    typedef logic [31:0]               ufb_bus_word_t;

endpackage : ufb_pkg

// *** ufb_chk.sv ***
/* Checker for the underflow bank: bus answer timing and flag capture.
   Assumes it is bound to ufb_underflow_status_bank. */
`timescale 1ns/1ps
`default_nettype none
module ufb_chk (
    input wire logic        clk_sys,     // Clock
    input wire logic        arst_n,      // Reset, active low
    input wire logic        wb_cyc_i,    // Cycle
    input wire logic        wb_stb_i,    // Strobe
    input wire logic        wb_we_i,     // Write
    input wire logic [15:0] wb_adr_i,    // Byte address
    input wire logic [31:0] wb_dat_o,    // Read data
    input wire logic        wb_ack_o,    // Acknowledge
    input wire logic [63:0] uflow_evt_i, // Event strobes
    input wire logic        irq_o        // Level interrupt
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire logic take = wb_cyc_i & wb_stb_i & !wb_ack_o;
    wire logic rd   = take & !wb_we_i;
    chk_ack_next: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    chk_ack_idle: assert property (!(wb_cyc_i & wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_upper_zero: assert property (rd |=> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    // Event two edges before the read is latched unless arst_n was low at that edge
    chk_word_a: assert property (rd && wb_adr_i == 16'h1638 && $past(uflow_evt_i[0], 2)
        && $past(arst_n, 2) |=> wb_dat_o[0]) else $error("chan 49 flag lost");
    chk_word_b: assert property (rd && wb_adr_i == 16'h163c && $past(uflow_evt_i[16], 2)
        && $past(arst_n, 2) |=> wb_dat_o[0]) else $error("chan 65 flag lost");
    chk_word_c: assert property (rd && wb_adr_i == 16'h1640 && $past(uflow_evt_i[47], 2)
        && $past(arst_n, 2) |=> wb_dat_o[15]) else $error("chan 96 flag lost");
    chk_word_d: assert property (rd && wb_adr_i == 16'h1644 && $past(uflow_evt_i[63], 2)
        && $past(arst_n, 2) |=> wb_dat_o[15]) else $error("chan 112 flag lost");
    // Interrupt rises only two edges after an event or a mask write was taken
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(|uflow_evt_i, 2)
        || $past(take && wb_we_i && wb_adr_i == 16'h1684, 2))
        else $error("interrupt rose without cause");
endmodule : ufb_chk
bind ufb_underflow_status_bank ufb_chk u_chk (.clk_sys, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .uflow_evt_i, .irq_o);
`default_nettype wire

// *** tb.sv ***
/* Self-checking bench for the underflow status bank.
   Assumes package, design and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb;
    import ufb_pkg::*;
    logic           clk_sys = 0, arst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic           wb_ack_o, irq_o;
    logic [15:0]    wb_adr_i = 0;
    logic [3:0]     wb_sel_i = 0;
    logic [63:0]    uflow_evt_i = 0;
    ufb_bus_word_t  wb_dat_i = 0, wb_dat_o, x, exp_q[$];
    ufb_flag_word_t r;
    int             n_mismatch = 0, samples_checked = 0, cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    ufb_underflow_status_bank DUT (.clk_sys, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .uflow_evt_i, .irq_o);
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // Event e rides on the edge that takes the request
    task automatic wb(input logic we, input logic [15:0] a, input ufb_bus_word_t d,
                      input logic [63:0] e, input logic [3:0] s = 4'hf);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i, uflow_evt_i} <=
            {2'b11, we, a, d, s, e};
        @(posedge clk_sys);
        uflow_evt_i <= '0;
        while (wb_ack_o !== 1'b1) @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task automatic rd(input logic [15:0] a, input ufb_bus_word_t v, input logic [63:0] e = 0);
        exp_q.push_back(v);
        wb(1'b0, a, '0, e);
    endtask : rd
    task automatic pulse(input logic [63:0] e);
        @(posedge clk_sys);
        uflow_evt_i <= e;
        @(posedge clk_sys);
        uflow_evt_i <= '0;
    endtask : pulse
    always @(posedge clk_sys) if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
        x = exp_q.pop_front();
        `CHK(wb_dat_o, x)
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(39395));
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            rd(16'h1638 + 16'(4 * w), '0);
            r = ufb_flag_word_t'($urandom) | 16'h8001;
            pulse(64'(r) << (16 * w));
            rd(16'h1638 + 16'(4 * w), {16'h0000, r});
            rd(16'h1638 + 16'(4 * w), '0);
            $display("test word %0d done", w);
        end
        pulse(64'h1);
        rd(16'h1638, 32'h0000_0001, 64'h2);
        rd(16'h1638, 32'h0000_0002);
        wb(1'b1, 16'h1638, 32'hffff_ffff, '0);
        rd(16'h1638, '0);
        rd(16'h1700, '0);
        $display("test clear and map done");
        wb(1'b1, 16'h1680, 32'h0000_000f, '0);
        wb(1'b1, 16'h1684, 32'h0000_0005, '0);
        rd(16'h1684, 32'h0000_0005);
        pulse(64'h1 << 40);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_o, 1'b1)
        pulse(64'h1 << 20);
        rd(16'h1680, 32'h0000_0006);
        wb(1'b1, 16'h1680, 32'h0000_0004, '0);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_o, 1'b0)
        wb(1'b1, 16'h1684, 32'h0000_0002, '0);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_o, 1'b1)
        // Mask write without byte lane 0 must be dropped
        wb(1'b1, 16'h1684, 32'h0000_0000, '0, 4'he);
        rd(16'h1684, 32'h0000_0002);
        $display("test interrupt done");
        pulse({64{1'b1}});
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK(irq_o, 1'b0)
        arst_n <= 1'b1;
        rd(16'h1640, '0);
        rd(16'h1684, '0);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
